// File: src/homing_params.svh
// constants of the homing error detector: offsets, field positions, reset values
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH
`define ADR_CMD 8'h00
`define ADR_METHOD 8'h04
`define ADR_FAST 8'h08
`define ADR_SLOW 8'h0c
`define ADR_RETLIM 8'h10
`define ADR_CFG 8'h14
`define ADR_STATUS 8'h18
`define ADR_EFFLIM 8'h1c
`define CMD_START_BIT 4
`define CFG_ABS_BIT 0
`define CFG_OTSETUP_BIT 1
`define CFG_LEGACY_BIT 2
`define CFG_HOME5_BIT 3
`define CFG_POS6_BIT 4
`define CFG_NEG7_BIT 5
`define CFG_RST 6'h3a
`define RETLIM_MAX 32'h00004e20
`define RETLIM_RST 16'h03e8
`define MIN_RPM 16'h000a
`define MOTOR_MAX_RPM 16'h1770
`endif

// File: src/homing_pkg.sv
// types shared by the homing error detector modules
package homing_pkg;
  typedef enum logic [1:0] {SUP_IDLE = 2'b00, SUP_RUN = 2'b01, SUP_FAIL = 2'b10} sup_state_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_HOME_SEARCH = 3'b001, PH_DECEL_LIMIT = 3'b010,
    PH_DECEL_HOME = 3'b011, PH_INDEX_SEARCH = 3'b100, PH_HARDSTOP_SEARCH = 3'b101
  } phase_t;
  typedef struct packed {
    logic rev_limit;
    logic rev_home;
    logic uses_index;
    logic switch_edge;
    logic hard_stop;
    logic preset_only;
    logic slow_exempt;
    logic need_home;
    logic need_pos;
    logic need_neg;
  } method_class_t;
  typedef struct packed {
    logic [31:0] cmd;
    logic start_prev;
    logic [7:0] method;
    logic [31:0] fast;
    logic [31:0] slow;
    logic [15:0] retlim;
    logic [5:0] cfg;
    sup_state_t sup;
    logic active;
    logic err;
    logic ot_fault;
    logic [11:0] cause;
    logic pos_prev;
    logic neg_prev;
    logic home_prev;
    logic pos_at_launch;
    logic neg_at_launch;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic ready;
    logic resp;
    logic [31:0] rdata;
  } det_state_t;
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } sync_state_t;
  typedef struct packed {
    logic [15:0] eff;
  } clamp_state_t;
endpackage : homing_pkg

// File: src/homing_sync.sv
// two-stage synchroniser for the home and over-travel switch pins
`timescale 1ns/100ps
module homing_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] pins,
  output logic [2:0] pins_sync
);
  import homing_pkg::*;
  sync_state_t r_q;
  sync_state_t r_d;

  // first stage feeds only the second stage
  always_comb begin
    r_d = r_q;
    r_d.meta = pins;
    r_d.sync = r_q.meta;
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign pins_sync = r_q.sync;
endmodule : homing_sync

// File: src/homing_speed_clamp.sv
// clamps the homing return speed limit between internal minimum and motor maximum
`timescale 1ns/100ps
`include "homing_params.svh"
module homing_speed_clamp (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] limit_set,
  output logic [15:0] limit_eff
);
  import homing_pkg::*;
  clamp_state_t r_q;
  clamp_state_t r_d;

  always_comb begin
    r_d = r_q;
    if (limit_set < `MIN_RPM) begin
      r_d.eff = `MIN_RPM;
    end else if (limit_set > `MOTOR_MAX_RPM) begin
      r_d.eff = `MOTOR_MAX_RPM;
    end else begin
      r_d.eff = limit_set;
    end
  end

  // registered so the effective limit is glitch free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign limit_eff = r_q.eff;

  a_clamp_min: assert property (@(posedge clk) disable iff (!rst_n)
    limit_set < `MIN_RPM |=> r_q.eff == `MIN_RPM) else $error("low limit not raised to minimum");
  a_clamp_max: assert property (@(posedge clk) disable iff (!rst_n)
    limit_set > `MOTOR_MAX_RPM |=> r_q.eff == `MOTOR_MAX_RPM) else $error("high limit not cut to maximum");
endmodule : homing_speed_clamp

// File: src/homing_error_detector.sv
// homing error supervisor with an AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "homing_params.svh"
module homing_error_detector (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic HOME_SWITCH,
  input wire logic POS_OVERTRAVEL_INPUT,
  input wire logic NEG_OVERTRAVEL_INPUT,
  input wire logic OP_ENABLED,
  input wire homing_pkg::phase_t PHASE,
  input wire logic DIRECTION_POS,
  output logic HOMING_ERROR,
  output logic OVERTRAVEL_PROTECTION_FAULT,
  output logic HOMING_ACTIVE,
  output logic [15:0] EFF_SPEED_LIMIT
);
  import homing_pkg::*;

  det_state_t r_q;
  det_state_t r_d;
  logic [2:0] pins_sync;
  logic home_s;
  logic pos_s;
  logic neg_s;
  logic [15:0] eff_limit;
  method_class_t mc;
  logic launch;
  logic running;
  logic both;
  logic lim_any;
  logic lim_rise;
  logic lim_fall;
  logic home_fall;
  logic escape;
  logic [11:0] launch_cause;
  logic [11:0] run_cause;
  logic launch_ot;
  logic run_ot;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // sorts a homing method number into the checks that apply to it
  function automatic method_class_t classify(input logic [7:0] m);
    method_class_t c;
    int mi;
    mi = int'($signed(m));
    c.rev_limit = (mi inside {1, 2, [7:14], 17, 18, [23:30]});
    c.rev_home = (mi inside {[3:14], [19:30]});
    c.uses_index = (mi inside {[1:14], 33, 34, -3, -4});
    c.switch_edge = (mi inside {[17:30]});
    c.hard_stop = (mi inside {[-4:-1]});
    c.preset_only = (mi inside {35, 37});
    c.slow_exempt = (mi inside {33, 34, 35, 37});
    c.need_home = (mi inside {[19:30]});
    c.need_pos = (mi inside {18, [23:26]});
    c.need_neg = (mi inside {17, [27:30]});
    return c;
  endfunction : classify

  // register read mux; unmapped addresses read as zero
  function automatic logic [31:0] read_word(input det_state_t s, input logic [15:0] eff);
    logic [31:0] w;
    w = 32'h00000000;
    case (s.addr)
      `ADR_CMD: w = s.cmd;
      `ADR_METHOD: w = {24'h000000, s.method};
      `ADR_FAST: w = s.fast;
      `ADR_SLOW: w = s.slow;
      `ADR_RETLIM: w = {16'h0000, s.retlim};
      `ADR_CFG: w = {26'h0000000, s.cfg};
      `ADR_STATUS: w = {4'h0, s.cause, 13'h0000, s.active, s.ot_fault, s.err};
      `ADR_EFFLIM: w = {16'h0000, eff};
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  // switches come from the machine, so they cross into this clock first
  homing_sync u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .pins({HOME_SWITCH, POS_OVERTRAVEL_INPUT, NEG_OVERTRAVEL_INPUT}),
    .pins_sync(pins_sync)
  );

  homing_speed_clamp u_clamp (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .limit_set(r_q.retlim),
    .limit_eff(eff_limit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // condition decode

  // switch levels and edges seen on the synchronised inputs
  assign home_s = pins_sync[2];
  assign pos_s = pins_sync[1];
  assign neg_s = pins_sync[0];
  assign mc = classify(r_q.method);
  assign both = pos_s & neg_s;
  assign lim_any = pos_s | neg_s;
  assign lim_rise = (pos_s & ~r_q.pos_prev) | (neg_s & ~r_q.neg_prev);
  assign lim_fall = (~pos_s & r_q.pos_prev) | (~neg_s & r_q.neg_prev);
  assign home_fall = ~home_s & r_q.home_prev;
  assign running = r_q.sup == SUP_RUN;
  assign addr_ok = HSEL & HTRANS[1] & HREADY;

  assign launch = r_q.cmd[`CMD_START_BIT] & ~r_q.start_prev;

  // leaving a limit that was already active at launch
  assign escape = (r_q.pos_at_launch & pos_s & ~neg_s & ~DIRECTION_POS) |
                  (r_q.neg_at_launch & neg_s & ~pos_s & DIRECTION_POS);

  // checks made at the launch edge; cause bit order is fixed in the status word
  always_comb begin
    launch_cause = 12'h000;
    launch_cause[0] = r_q.cfg[`CFG_ABS_BIT] & r_q.cfg[`CFG_LEGACY_BIT];
    launch_cause[1] = ~OP_ENABLED & ~mc.preset_only;
    launch_cause[2] = ((r_q.fast == 32'h00000000) & ~mc.preset_only) |
                      ((r_q.slow == 32'h00000000) & ~mc.slow_exempt);
    launch_cause[3] = both & r_q.cfg[`CFG_OTSETUP_BIT];
    launch_cause[10] = mc.switch_edge & ((mc.need_home & ~r_q.cfg[`CFG_HOME5_BIT]) |
                       (mc.need_pos & ~r_q.cfg[`CFG_POS6_BIT]) | (mc.need_neg & ~r_q.cfg[`CFG_NEG7_BIT]));
  end

  assign launch_ot = both & ~r_q.cfg[`CFG_OTSETUP_BIT];
  assign run_ot = running & both & ~r_q.cfg[`CFG_OTSETUP_BIT];

  // checks made while the search phases run; phase comes from the trajectory generator
  always_comb begin
    run_cause = 12'h000;
    if (running) begin
      run_cause[3] = both & r_q.cfg[`CFG_OTSETUP_BIT];
      run_cause[4] = mc.rev_limit & (PHASE == PH_DECEL_LIMIT) & lim_fall;
      run_cause[5] = mc.rev_home & (PHASE == PH_DECEL_HOME) & home_fall;
      run_cause[6] = mc.rev_home & (PHASE == PH_DECEL_HOME) & lim_rise;
      run_cause[7] = ~mc.rev_limit & (PHASE == PH_HOME_SEARCH) & lim_any & ~escape;
      run_cause[8] = mc.uses_index & (PHASE == PH_INDEX_SEARCH) & lim_rise;
      run_cause[9] = ~mc.rev_limit & (PHASE == PH_INDEX_SEARCH) & lim_any & ~escape;
      run_cause[11] = mc.hard_stop & (PHASE == PH_HARDSTOP_SEARCH) & lim_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_d = r_q;
    r_d.start_prev = r_q.cmd[`CMD_START_BIT];
    r_d.pos_prev = pos_s;
    r_d.neg_prev = neg_s;
    r_d.home_prev = home_s;
    r_d.resp = 1'b0;
    r_d.wr_pend = 1'b0;
    r_d.rd_pend = 1'b0;
    r_d.ready = 1'b1;
    // write data phase: data stand on the bus one cycle after the address
    if (r_q.wr_pend) begin
      case (r_q.addr)
        `ADR_CMD: r_d.cmd = HWDATA;
        `ADR_METHOD: r_d.method = HWDATA[7:0];
        `ADR_FAST: r_d.fast = HWDATA;
        `ADR_SLOW: r_d.slow = HWDATA;
        `ADR_RETLIM: if (HWDATA <= `RETLIM_MAX) r_d.retlim = HWDATA[15:0];
        `ADR_CFG: r_d.cfg = HWDATA[5:0];
        default: r_d.cfg = r_q.cfg;
      endcase
    end
    // read takes one wait state so it sees any write that just completed
    if (r_q.rd_pend) begin
      r_d.rdata = read_word(r_q, eff_limit);
    end
    if (addr_ok) begin
      r_d.addr = HADDR[7:0];
      r_d.wr_pend = HWRITE;
      r_d.rd_pend = ~HWRITE;
      r_d.ready = HWRITE;
    end
    if (launch) begin
      r_d.pos_at_launch = pos_s;
      r_d.neg_at_launch = neg_s;
      r_d.cause = launch_cause;
      r_d.err = |launch_cause;
      r_d.ot_fault = launch_ot;
    end else begin
      r_d.cause = r_q.cause | run_cause;
      r_d.err = r_q.err | (|run_cause);
      r_d.ot_fault = r_q.ot_fault | run_ot;
    end
    // supervisor: a raised error stops the search and holds until relaunch
    if (launch) begin
      if (|launch_cause) begin
        r_d.sup = SUP_FAIL;
      end else if (launch_ot) begin
        r_d.sup = SUP_IDLE;
      end else begin
        r_d.sup = SUP_RUN;
      end
    end else begin
      case (r_q.sup)
        SUP_IDLE: r_d.sup = SUP_IDLE;
        SUP_RUN: begin
          if (|run_cause) begin
            r_d.sup = SUP_FAIL;
          end else if (run_ot | ~r_q.cmd[`CMD_START_BIT]) begin
            r_d.sup = SUP_IDLE;
          end else begin
            r_d.sup = SUP_RUN;
          end
        end
        SUP_FAIL: r_d.sup = SUP_FAIL;
        default: r_d.sup = SUP_IDLE;
      endcase
    end
    r_d.active = r_d.sup == SUP_RUN;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      r_q <= '0;
      r_q.method <= 8'h00;
      r_q.retlim <= `RETLIM_RST;
      r_q.cfg <= `CFG_RST;
      r_q.sup <= SUP_IDLE;
      r_q.ready <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register or the clamp flop
  assign HRDATA = r_q.rdata;
  assign HREADYOUT = r_q.ready;
  assign HRESP = r_q.resp;
  assign HOMING_ERROR = r_q.err;
  assign OVERTRAVEL_PROTECTION_FAULT = r_q.ot_fault;
  assign HOMING_ACTIVE = r_q.active;
  assign EFF_SPEED_LIMIT = eff_limit;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_retlim_range: assert property (
    {16'h0000, r_q.retlim} <= `RETLIM_MAX) else $error("return limit out of range");
  // register side: a refused write must leave the stored limit untouched
  a_retlim_keep: assert property (
    r_q.wr_pend && r_q.addr == `ADR_RETLIM && HWDATA > `RETLIM_MAX |=> $stable(r_q.retlim))
    else $error("out of range return limit accepted");
  a_cause_err: assert property (
    (|r_q.cause) |-> r_q.err) else $error("cause set without error");
  a_abs_mode: assert property (
    launch && r_q.cfg[`CFG_ABS_BIT] && r_q.cfg[`CFG_LEGACY_BIT] |=> r_q.err && r_q.cause[0])
    else $error("absolute mode launch not flagged");
  a_op_disabled: assert property (
    launch && !OP_ENABLED && !mc.preset_only |=> r_q.err ##1 !HOMING_ACTIVE)
    else $error("disabled drive launch not flagged");
  a_zero_speed: assert property (
    launch && r_q.fast == 32'h00000000 && !mc.preset_only |=> r_q.cause[2])
    else $error("zero fast speed not flagged");
  a_both_split: assert property (
    running && both && !r_q.cfg[`CFG_OTSETUP_BIT] |=> r_q.ot_fault && !r_q.cause[3])
    else $error("both limits not routed to overtravel fault");
  a_limit_pen: assert property (
    running && mc.rev_limit && PHASE == PH_DECEL_LIMIT && lim_fall |=> r_q.err && !r_q.active)
    else $error("limit penetration not flagged");
  a_home_pen: assert property (
    running && mc.rev_home && PHASE == PH_DECEL_HOME && home_fall |=> r_q.cause[5])
    else $error("home penetration not flagged");
  a_err_sticky: assert property (
    r_q.err && !launch |=> r_q.err [*1] ##0 (r_q.sup == SUP_FAIL))
    else $error("error dropped without relaunch");
  a_launch_edge: assert property (
    $fell(r_q.err) |-> $past(launch)) else $error("error cleared without launch edge");
  // launch and search-phase checks: each condition must reach its status bit one edge later, except an escape, which must leave cause bit 7 clear
  a_both_launch: assert property (
    launch && both && r_q.cfg[`CFG_OTSETUP_BIT] |=> r_q.err && r_q.cause[3])
    else $error("both limits at launch not flagged");
  a_ot_launch: assert property (
    launch && both && !r_q.cfg[`CFG_OTSETUP_BIT] |=> r_q.ot_fault && !r_q.cause[3])
    else $error("both limits at launch not routed to overtravel fault");
  a_home_decel: assert property (
    running && mc.rev_home && PHASE == PH_DECEL_HOME && lim_rise |=> r_q.cause[6])
    else $error("limit rise in home deceleration not flagged");
  a_home_search: assert property (
    running && !mc.rev_limit && PHASE == PH_HOME_SEARCH && lim_any && !escape |=> r_q.cause[7])
    else $error("limit in home search not flagged");
  a_index_edge: assert property (
    running && mc.uses_index && PHASE == PH_INDEX_SEARCH && lim_rise |=> r_q.cause[8])
    else $error("limit rise in index search not flagged");
  a_index_level: assert property (
    running && !mc.rev_limit && PHASE == PH_INDEX_SEARCH && lim_any && !escape |=> r_q.cause[9])
    else $error("limit in index search not flagged");
  a_slot_missing: assert property (
    launch && mc.need_home && !r_q.cfg[`CFG_HOME5_BIT] |=> r_q.err && r_q.cause[10])
    else $error("home switch off its slot not flagged");
  a_hard_stop: assert property (
    running && mc.hard_stop && PHASE == PH_HARDSTOP_SEARCH && lim_any |=> r_q.err && r_q.cause[11])
    else $error("limit before hard stop not flagged");
  a_escape_ok: assert property (
    running && escape && PHASE == PH_HOME_SEARCH |=> !r_q.cause[7])
    else $error("leaving a launch limit flagged as error");
  // the error doubles as the stop request, so the search must not stay active
  a_err_stops: assert property (
    r_q.err |-> !r_q.active)
    else $error("search still active with error raised");
endmodule : homing_error_detector

// File: tb/homing_switch_model.sv
// behavioural home and over-travel switches facing the homing error detector
`timescale 1ns/100ps
module homing_switch_model (
  input wire logic clk,
  input wire logic [2:0] want,
  output logic home_pin,
  output logic pos_pin,
  output logic neg_pin
);
  logic [2:0] lvl = 3'h0;
  // contacts move on the rising edge itself through a nonblocking update, so the detector samples the old level at that edge
  always @(posedge clk) begin
    lvl <= want;
  end
  // high means the switch is made
  assign {home_pin, pos_pin, neg_pin} = lvl;
endmodule : homing_switch_model

// File: tb/homing_error_detector_tb_top.sv
// self-checking testbench of the homing error detector
`timescale 1ns/100ps
`include "homing_params.svh"
module homing_error_detector_tb_top;
  import homing_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic op_en = 1'b1;
  phase_t phase = PH_IDLE;
  logic dir_pos = 1'b0;
  logic [2:0] want = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, home_sw, pos_sw, neg_sw, herr, ot_flt, h_act;
  logic [15:0] eff;
  int miscompares = 0;
  int n_tests = 0;

  ////////////////////////////////////////////////////////////////
  // clock and instances
  always #5 sys_clk = ~sys_clk;
  homing_switch_model homing_switch_model_i (.clk(sys_clk), .want(want), .home_pin(home_sw), .pos_pin(pos_sw),
    .neg_pin(neg_sw));
  // one slave, so its hreadyout is the bus hready
  homing_error_detector homing_error_detector_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HOME_SWITCH(home_sw), .POS_OVERTRAVEL_INPUT(pos_sw),
    .NEG_OVERTRAVEL_INPUT(neg_sw), .OP_ENABLED(op_en), .PHASE(phase), .DIRECTION_POS(dir_pos),
    .HOMING_ERROR(herr), .OVERTRAVEL_PROTECTION_FAULT(ot_flt), .HOMING_ACTIVE(h_act), .EFF_SPEED_LIMIT(eff));

  ////////////////////////////////////////////////////////////////
  // comparison, bus and verdict tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // ready is looked at mid-cycle, so the value standing at the next rising edge is the one used
  task automatic wait_ready(output logic [31:0] d);
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
    @(posedge sys_clk);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] junk;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready(junk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0;
    wait_ready(rd);
    check("hresp", hresp, 1'b0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    bus(1'b1, a, d, junk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(name, d, exp);
  endtask : rd_chk

  task automatic speed(input logic [31:0] v, input logic [31:0] kept, input logic [15:0] lim);
    wr(`ADR_RETLIM, v);
    repeat (3) @(posedge sys_clk);
    check("eff port", eff, lim);
    rd_chk(`ADR_EFFLIM, {16'h0, lim}, "efflim");
    rd_chk(`ADR_RETLIM, kept, "retlim");
    $display("speed %0d done", v);
  endtask : speed

  // one launch: pins at launch, then a phase with two pin steps, then the verdict
  task automatic run_case(input int id, input logic [7:0] m, input logic [5:0] c, input logic [15:0] f,
    input logic [15:0] s, input logic op, input phase_t ph, input logic dp, input logic [2:0] p0,
    input logic [2:0] p1, input logic [2:0] p2, input logic e, input logic t, input int cb);
    logic [31:0] st;
    want <= p0;
    op_en <= op;
    dir_pos <= dp;
    wr(`ADR_METHOD, {24'h0, m});
    wr(`ADR_CFG, {26'h0, c});
    wr(`ADR_FAST, {16'h0, f});
    wr(`ADR_SLOW, {16'h0, s});
    wr(`ADR_CMD, 32'h10);
    repeat (3) @(posedge sys_clk);
    phase <= ph;
    want <= p1;
    repeat (5) @(posedge sys_clk);
    want <= p2;
    repeat (5) @(posedge sys_clk);
    check("error", herr, e);
    check("ot fault", ot_flt, t);
    check("active", h_act, !(e | t));
    bus(1'b0, `ADR_STATUS, 32'h0, st);
    check("status", st[2:0], {~(e | t), t, e});
    if (cb > 0) check("cause", st[cb], 1'b1);
    // dropping the start bit must not clear a raised error
    wr(`ADR_CMD, 32'h0);
    phase <= PH_IDLE;
    @(posedge sys_clk);
    check("held", herr, e);
    $display("case %0d done", id);
  endtask : run_case

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs about a thousand cycles, twenty thousand is ample
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(`ADR_CMD, 32'h0, "cmd rst");
    rd_chk(`ADR_METHOD, 32'h0, "method rst");
    rd_chk(`ADR_FAST, 32'h0, "fast rst");
    rd_chk(`ADR_RETLIM, {16'h0, `RETLIM_RST}, "retlim rst");
    rd_chk(`ADR_CFG, {26'h0, `CFG_RST}, "cfg rst");
    rd_chk(`ADR_STATUS, 32'h0, "status rst");
    wr(`ADR_STATUS, 32'hffffffff);
    rd_chk(`ADR_STATUS, 32'h0, "status ro");
    wr(8'h24, 32'h1234);
    rd_chk(8'h24, 32'h0, "unmapped");
    $display("register test done");
    speed(32'd5, 32'd5, `MIN_RPM);
    speed(32'd10, 32'd10, `MIN_RPM);
    speed(32'd6001, 32'd6001, `MOTOR_MAX_RPM);
    speed(`RETLIM_MAX, `RETLIM_MAX, `MOTOR_MAX_RPM);
    speed(`RETLIM_MAX + 32'd1, `RETLIM_MAX, `MOTOR_MAX_RPM);
    speed(32'd6000, 32'd6000, `MOTOR_MAX_RPM);
    run_case(1, 8'd1, 6'h3a, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 0, 0, 0);
    run_case(2, 8'd1, 6'h3f, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 1, 0, 16);
    run_case(3, 8'd1, 6'h3b, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 0, 0, 0);
    run_case(4, 8'd1, 6'h3a, 16'd100, 16'd10, 1'b0, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 1, 0, 17);
    run_case(5, 8'd35, 6'h3a, 16'd0, 16'd0, 1'b0, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 0, 0, 0);
    run_case(6, 8'd37, 6'h3a, 16'd0, 16'd0, 1'b0, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 0, 0, 0);
    run_case(7, 8'd1, 6'h3a, 16'd0, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 1, 0, 18);
    run_case(8, 8'd33, 6'h3a, 16'd100, 16'd0, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 0, 0, 0);
    run_case(9, 8'd1, 6'h3a, 16'd100, 16'd0, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 1, 0, 18);
    run_case(10, 8'd1, 6'h3a, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h3, 3'h3, 3'h3, 1, 0, 19);
    run_case(11, 8'd1, 6'h3a, 16'd100, 16'd10, 1'b1, PH_HOME_SEARCH, 1'b0, 3'h0, 3'h1, 3'h3, 1, 0, 19);
    run_case(12, 8'd1, 6'h38, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h3, 3'h3, 3'h3, 0, 1, 0);
    run_case(13, 8'd1, 6'h3a, 16'd100, 16'd10, 1'b1, PH_DECEL_LIMIT, 1'b0, 3'h0, 3'h1, 3'h0, 1, 0, 20);
    run_case(14, 8'd3, 6'h3a, 16'd100, 16'd10, 1'b1, PH_DECEL_HOME, 1'b0, 3'h0, 3'h4, 3'h0, 1, 0, 21);
    run_case(15, 8'd3, 6'h3a, 16'd100, 16'd10, 1'b1, PH_DECEL_HOME, 1'b0, 3'h0, 3'h4, 3'h6, 1, 0, 22);
    run_case(16, 8'd3, 6'h3a, 16'd100, 16'd10, 1'b1, PH_HOME_SEARCH, 1'b0, 3'h0, 3'h0, 3'h2, 1, 0, 23);
    run_case(17, 8'd1, 6'h3a, 16'd100, 16'd10, 1'b1, PH_INDEX_SEARCH, 1'b0, 3'h0, 3'h0, 3'h2, 1, 0, 24);
    run_case(18, 8'd33, 6'h3a, 16'd100, 16'd10, 1'b1, PH_INDEX_SEARCH, 1'b0, 3'h0, 3'h0, 3'h2, 1, 0, 25);
    run_case(19, 8'd19, 6'h32, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 1, 0, 26);
    run_case(20, 8'd17, 6'h1a, 16'd100, 16'd10, 1'b1, PH_IDLE, 1'b0, 3'h0, 3'h0, 3'h0, 1, 0, 26);
    run_case(21, 8'hff, 6'h3a, 16'd100, 16'd10, 1'b1, PH_HARDSTOP_SEARCH, 1'b0, 3'h0, 3'h0, 3'h1, 1, 0, 27);
    run_case(22, 8'd3, 6'h3a, 16'd100, 16'd10, 1'b1, PH_HOME_SEARCH, 1'b1, 3'h1, 3'h1, 3'h1, 0, 0, 0);
    run_case(23, 8'd3, 6'h3a, 16'd100, 16'd10, 1'b1, PH_HOME_SEARCH, 1'b0, 3'h1, 3'h1, 3'h1, 1, 0, 23);
    run_case(24, 8'd1, 6'h38, 16'd100, 16'd10, 1'b1, PH_HOME_SEARCH, 1'b0, 3'h0, 3'h1, 3'h3, 0, 1, 0);
    give_verdict();
  end
endmodule : homing_error_detector_tb_top
